// ---- ubc_core.sv ----
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
module ubc_core
    import ubc_pkg::*;
#(
    parameter int DEPTH = 16
)(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic rxd_i,
    output logic txd_o,
    output logic irq_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} ubc_tx_st_t;
    typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} ubc_rx_st_t;

    function automatic logic [4:0] trig_lvl(input logic [1:0] s);
        case (s)
            2'h0: return 5'h01;
            2'h1: return 5'h04;
            2'h2: return 5'h08;
            default: return 5'h0e;
        endcase
    endfunction

    function automatic logic par_bit(input logic p, input logic [7:0] l);
        return l[LCR_STICK] ? ~l[LCR_EPS] : (p ^ ~l[LCR_EPS]);
    endfunction

    logic [7:0] ier_reg, fcr_reg, lcr_reg, mcr_reg, dll_reg, dlm_reg;
    logic [31:0] prdata_reg;
    logic irq_reg, oe_reg, tick_reg, to_reg, rx_prev_reg, dl_wr_reg;
    logic [1:0] pre_reg;
    logic [15:0] brg_reg;
    logic [7:0] tx_mem [DEPTH];
    ubc_rx_ent_t rx_mem [DEPTH];
    logic [AW-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
    logic [AW:0] tx_cnt_reg, rx_cnt_reg;
    ubc_tx_st_t tx_st_reg;
    ubc_rx_st_t rx_st_reg;
    logic [3:0] tx_smp_reg, rx_smp_reg, tx_bit_reg, rx_bit_reg;
    logic [7:0] tx_sh_reg, rx_sh_reg;
    logic txd_reg, tx_par_reg, rx_par_reg, pe_reg, stop2_reg;
    logic [9:0] to_cnt_reg;

    logic wr_acc, rd_acc, wr_thr, rd_rhr, mapped, fifo_en, pre_tick;
    logic tx_pop, rx_push, rx_pop, thre, temt, dr;
    logic [15:0] div_eff;
    logic [3:0] nbits, isr_id;
    logic [9:0] to_lim;
    logic [AW:0] cap;
    ubc_rx_ent_t head, rx_ent;

    ////////////////////////////////////////////////////////////////////////
    // apb slave
    assign wr_acc = psel_i & penable_i & pwrite_i;
    assign rd_acc = psel_i & penable_i & ~pwrite_i;
    assign wr_thr = wr_acc && paddr_i == A_DATA;
    assign rd_rhr = rd_acc && paddr_i == A_DATA;
    assign mapped = paddr_i <= A_DLM && paddr_i[1:0] == 2'h0;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;
    assign prdata_o = prdata_reg;
    assign irq_o = irq_reg;
    assign fifo_en = fcr_reg[FCR_EN];
    assign cap = fifo_en ? FULL : (AW+1)'(1);
    assign nbits = WORD_MIN + {2'h0, lcr_reg[1:0]};

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ier_reg <= CTL_RST;
            fcr_reg <= CTL_RST;
            lcr_reg <= CTL_RST;
            mcr_reg <= CTL_RST;
            dll_reg <= DLL_RST;
            dlm_reg <= DLM_RST;
            dl_wr_reg <= 1'b0;
        end
        else if (wr_acc)
        begin
            case (paddr_i)
                A_IER: ier_reg <= pwdata_i[7:0];
                A_FCR: fcr_reg <= {pwdata_i[7:3], 2'h0, pwdata_i[0]};
                A_LCR: lcr_reg <= pwdata_i[7:0];
                A_MCR: mcr_reg <= pwdata_i[7:0];
                A_DLL: dll_reg <= pwdata_i[7:0];
                A_DLM: dlm_reg <= pwdata_i[7:0];
                default: ;
            endcase
            if (paddr_i == A_DLL || paddr_i == A_DLM)
                dl_wr_reg <= 1'b1;
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            prdata_reg <= 32'h0;
        else if (psel_i && !penable_i && !pwrite_i)
        begin
            case (paddr_i)
                A_DATA: prdata_reg <= {24'h0, head.data};
                A_IER: prdata_reg <= {24'h0, ier_reg};
                A_ISR: prdata_reg <= {24'h0, {2{fifo_en}}, 2'h0, isr_id};
                A_FCR: prdata_reg <= {24'h0, fcr_reg};
                A_LCR: prdata_reg <= {24'h0, lcr_reg};
                A_MCR: prdata_reg <= {24'h0, mcr_reg};
                A_LSR: prdata_reg <= {24'h0, fifo_en & dr & (head.brk | head.fe | head.pe),
                    temt, thre, dr ? {head.brk, head.fe, head.pe} : 3'h0,
                    oe_reg, dr};
                A_DLL: prdata_reg <= {24'h0, dll_reg};
                A_DLM: prdata_reg <= {24'h0, dlm_reg};
                default: prdata_reg <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler and baud generator
    assign pre_tick = mcr_reg[MCR_PRESC] ? pre_reg == PRESC_LAST : 1'b1;
    assign div_eff = {dlm_reg, dll_reg} == 16'h0 ? 16'h1 : {dlm_reg, dll_reg};

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pre_reg <= 2'h0;
            brg_reg <= 16'h0;
            tick_reg <= 1'b0;
        end
        else
        begin
            pre_reg <= pre_reg + 2'h1;
            tick_reg <= pre_tick && brg_reg >= div_eff - 16'h1;
            if (pre_tick)
                brg_reg <= brg_reg >= div_eff - 16'h1 ? 16'h0 : brg_reg + 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit fifo
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_wp_reg <= '0;
            tx_rp_reg <= '0;
            tx_cnt_reg <= '0;
        end
        else if (wr_acc && paddr_i == A_FCR && pwdata_i[FCR_TXCLR])
        begin
            tx_wp_reg <= '0;
            tx_rp_reg <= '0;
            tx_cnt_reg <= '0;
        end
        else
        begin
            if (wr_thr && tx_cnt_reg < cap)
            begin
                tx_mem[tx_wp_reg] <= pwdata_i[7:0];
                tx_wp_reg <= tx_wp_reg + 1'b1;
            end
            if (tx_pop)
                tx_rp_reg <= tx_rp_reg + 1'b1;
            tx_cnt_reg <= tx_cnt_reg + (AW+1)'(wr_thr && tx_cnt_reg < cap) - (AW+1)'(tx_pop);
        end
    end

    assign thre = tx_cnt_reg == '0;
    assign temt = thre && tx_st_reg == T_IDLE;
    assign tx_pop = tick_reg && tx_st_reg == T_IDLE && !thre;
    assign txd_o = txd_reg;

    ////////////////////////////////////////////////////////////////////////
    // transmitter
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_st_reg <= T_IDLE;
            txd_reg <= 1'b1;
            tx_smp_reg <= 4'h0;
            tx_bit_reg <= 4'h0;
            tx_sh_reg <= 8'h0;
            tx_par_reg <= 1'b0;
            stop2_reg <= 1'b0;
        end
        else if (tick_reg)
        begin
            tx_smp_reg <= tx_smp_reg + 4'h1;
            case (tx_st_reg)
                T_IDLE:
                    if (!thre)
                    begin
                        tx_st_reg <= T_START;
                        txd_reg <= 1'b0;
                        tx_sh_reg <= tx_mem[tx_rp_reg];
                        tx_smp_reg <= 4'h0;
                    end
                T_START:
                    if (tx_smp_reg == SMP_LAST)
                    begin
                        tx_st_reg <= T_DATA;
                        txd_reg <= tx_sh_reg[0];
                        tx_par_reg <= tx_sh_reg[0];
                        tx_bit_reg <= 4'h0;
                    end
                T_DATA:
                    if (tx_smp_reg == SMP_LAST)
                    begin
                        if (tx_bit_reg == nbits - 4'h1)
                        begin
                            tx_st_reg <= lcr_reg[LCR_PEN] ? T_PAR : T_STOP;
                            txd_reg <= lcr_reg[LCR_PEN] ? par_bit(tx_par_reg, lcr_reg) : 1'b1;
                            stop2_reg <= 1'b0;
                        end
                        else
                        begin
                            tx_sh_reg <= tx_sh_reg >> 1;
                            txd_reg <= tx_sh_reg[1];
                            tx_par_reg <= tx_par_reg ^ tx_sh_reg[1];
                            tx_bit_reg <= tx_bit_reg + 4'h1;
                        end
                    end
                T_PAR:
                    if (tx_smp_reg == SMP_LAST)
                    begin
                        tx_st_reg <= T_STOP;
                        txd_reg <= 1'b1;
                    end
                T_STOP:
                    if (tx_smp_reg == SMP_LAST)
                    begin
                        stop2_reg <= 1'b1;
                        if (stop2_reg || !lcr_reg[LCR_STB])
                            tx_st_reg <= T_IDLE;
                    end
                default: tx_st_reg <= T_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_st_reg <= R_IDLE;
            rx_prev_reg <= 1'b1;
            rx_smp_reg <= 4'h0;
            rx_bit_reg <= 4'h0;
            rx_sh_reg <= 8'h0;
            rx_par_reg <= 1'b0;
            pe_reg <= 1'b0;
        end
        else
        begin
            rx_prev_reg <= rxd_i;
            if (rx_st_reg == R_IDLE)
            begin
                if (rx_prev_reg && !rxd_i)
                begin
                    rx_st_reg <= R_START;
                    rx_smp_reg <= 4'h0;
                    rx_sh_reg <= 8'h0;
                    rx_bit_reg <= 4'h0;
                    rx_par_reg <= 1'b0;
                    pe_reg <= 1'b0;
                end
            end
            else if (tick_reg)
            begin
                rx_smp_reg <= rx_smp_reg + 4'h1;
                case (rx_st_reg)
                    R_START:
                        if (rx_smp_reg == SMP_MID)
                        begin
                            rx_st_reg <= rxd_i ? R_IDLE : R_DATA;
                            rx_smp_reg <= 4'h0;
                        end
                    R_DATA:
                        if (rx_smp_reg == SMP_LAST)
                        begin
                            rx_sh_reg[rx_bit_reg[2:0]] <= rxd_i;
                            rx_par_reg <= rx_par_reg ^ rxd_i;
                            rx_bit_reg <= rx_bit_reg + 4'h1;
                            if (rx_bit_reg == nbits - 4'h1)
                                rx_st_reg <= lcr_reg[LCR_PEN] ? R_PAR : R_STOP;
                        end
                    R_PAR:
                        if (rx_smp_reg == SMP_LAST)
                        begin
                            pe_reg <= rxd_i != par_bit(rx_par_reg, lcr_reg);
                            rx_st_reg <= R_STOP;
                        end
                    R_STOP:
                        if (rx_smp_reg == SMP_LAST)
                            rx_st_reg <= R_IDLE;
                    default: rx_st_reg <= R_IDLE;
                endcase
            end
        end
    end

    assign rx_ent = '{brk: !rxd_i && rx_sh_reg == 8'h0, fe: !rxd_i, pe: pe_reg, data: rx_sh_reg};
    assign rx_push = tick_reg && rx_st_reg == R_STOP && rx_smp_reg == SMP_LAST;
    assign rx_pop = rd_rhr && dr;
    assign dr = rx_cnt_reg != '0;
    assign head = rx_mem[rx_rp_reg];

    ////////////////////////////////////////////////////////////////////////
    // receive fifo and overrun
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_wp_reg <= '0;
            rx_rp_reg <= '0;
            rx_cnt_reg <= '0;
            oe_reg <= 1'b0;
        end
        else
        begin
            if (rx_push && rx_cnt_reg == cap)
                oe_reg <= 1'b1;
            else if (rd_acc && paddr_i == A_LSR)
                oe_reg <= 1'b0;
            if (wr_acc && paddr_i == A_FCR && pwdata_i[FCR_RXCLR])
            begin
                rx_wp_reg <= '0;
                rx_rp_reg <= '0;
                rx_cnt_reg <= '0;
            end
            else
            begin
                if (rx_push && rx_cnt_reg < cap)
                begin
                    rx_mem[rx_wp_reg] <= rx_ent;
                    rx_wp_reg <= rx_wp_reg + 1'b1;
                end
                if (rx_pop)
                    rx_rp_reg <= rx_rp_reg + 1'b1;
                rx_cnt_reg <= rx_cnt_reg + (AW+1)'(rx_push && rx_cnt_reg < cap)
                    - (AW+1)'(rx_pop);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive time-out
    assign to_lim = 10'((TO_WORDS * nbits + TO_BITS) * SMP_PER_BIT);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            to_cnt_reg <= 10'h0;
            to_reg <= 1'b0;
        end
        else
        begin
            if (rx_push || rd_rhr || !dr)
                to_cnt_reg <= 10'h0;
            else if (tick_reg && to_cnt_reg != to_lim)
                to_cnt_reg <= to_cnt_reg + 10'h1;
            if (fifo_en && dr && to_cnt_reg == to_lim)
                to_reg <= 1'b1;
            else if (rd_rhr || rx_push || !dr)
                to_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt identification
    always_comb
    begin
        if (ier_reg[IER_RLS] && (oe_reg || (dr && (head.brk | head.fe | head.pe))))
            isr_id = ID_RLS;
        else if (ier_reg[IER_RDA] && (fifo_en ? rx_cnt_reg >= trig_lvl(fcr_reg[FCR_RXTRG +: 2])
                : dr))
            isr_id = ID_RDA;
        else if (ier_reg[IER_RDA] && to_reg)
            isr_id = ID_TO;
        else if (ier_reg[IER_THR] && (fifo_en ? tx_cnt_reg < trig_lvl(fcr_reg[FCR_TXTRG +: 2])
                : thre))
            isr_id = ID_THR;
        else
            isr_id = ID_NONE;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            irq_reg <= 1'b0;
        else
            irq_reg <= isr_id != ID_NONE;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_presc;
        @(posedge clk_i) disable iff (!rst_n_i)
        (mcr_reg[MCR_PRESC] && pre_tick) |=> !pre_tick [*3];
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler not dividing by 4");

    property p_div_default;
        @(posedge clk_i) disable iff (!rst_n_i)
        !dl_wr_reg |-> {dlm_reg, dll_reg} == 16'h0001;
    endproperty
    a_div_default: assert property (p_div_default) else $error("divisor default wrong");

    property p_bit_len;
        @(posedge clk_i) disable iff (!rst_n_i)
        ($past(tx_st_reg) != T_IDLE && $changed(txd_reg))
            |-> $past(tick_reg) && $past(tx_smp_reg) == SMP_LAST;
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("tx bit not 16 samples");

    property p_lsb_first;
        @(posedge clk_i) disable iff (!rst_n_i)
        (tx_st_reg == T_START && tick_reg && tx_smp_reg == SMP_LAST)
            |=> txd_reg == $past(tx_sh_reg[0]) && tx_st_reg == T_DATA;
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("first data bit not lsb");

    property p_thr_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_thr && thre && !(wr_acc && paddr_i == A_FCR)) |=> !thre && !temt;
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("holding write not seen");

    property p_temt;
        @(posedge clk_i) disable iff (!rst_n_i)
        temt |-> txd_reg && tx_st_reg == T_IDLE;
    endproperty
    a_temt: assert property (p_temt) else $error("empty while shifting");

    property p_false_start;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rx_st_reg == R_START && tick_reg && rx_smp_reg == SMP_MID && rxd_i)
            |=> rx_st_reg == R_IDLE && rx_cnt_reg <= $past(rx_cnt_reg);
    endproperty
    a_false_start: assert property (p_false_start) else $error("false start kept");

    property p_start_edge;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rx_st_reg == R_IDLE && rx_prev_reg && !rxd_i) |=> rx_st_reg == R_START && rx_smp_reg == 4'h0;
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("start edge missed");

    property p_rx_pop;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rx_pop && !rx_push && !wr_acc) |=> rx_cnt_reg == $past(rx_cnt_reg) - 1'b1
            && rx_rp_reg == $past(rx_rp_reg) + 1'b1;
    endproperty
    a_rx_pop: assert property (p_rx_pop) else $error("rx read did not advance");

    property p_timeout;
        @(posedge clk_i) disable iff (!rst_n_i)
        (fifo_en && dr && to_cnt_reg == to_lim) |=> to_reg;
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out not raised");
endmodule // ubc_core

// ---- ubc_pkg.sv ----
package ubc_pkg;
    // register byte offsets
    localparam logic [7:0] A_DATA = 8'h00;
    localparam logic [7:0] A_IER = 8'h04;
    localparam logic [7:0] A_ISR = 8'h08;
    localparam logic [7:0] A_FCR = 8'h0c;
    localparam logic [7:0] A_LCR = 8'h10;
    localparam logic [7:0] A_MCR = 8'h14;
    localparam logic [7:0] A_LSR = 8'h18;
    localparam logic [7:0] A_DLL = 8'h1c;
    localparam logic [7:0] A_DLM = 8'h20;
    // reset values
    localparam logic [7:0] DLL_RST = 8'h01;
    localparam logic [7:0] DLM_RST = 8'h00;
    localparam logic [7:0] CTL_RST = 8'h00;
    // field positions
    localparam int MCR_PRESC = 7;
    localparam int FCR_EN = 0;
    localparam int FCR_RXCLR = 1;
    localparam int FCR_TXCLR = 2;
    localparam int FCR_TXTRG = 4;
    localparam int FCR_RXTRG = 6;
    localparam int IER_RDA = 0;
    localparam int IER_THR = 1;
    localparam int IER_RLS = 2;
    localparam int LCR_STB = 2;
    localparam int LCR_PEN = 3;
    localparam int LCR_EPS = 4;
    localparam int LCR_STICK = 5;
    // interrupt ids
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_THR = 4'h2;
    localparam logic [3:0] ID_RDA = 4'h4;
    localparam logic [3:0] ID_RLS = 4'h6;
    localparam logic [3:0] ID_TO = 4'hc;
    // timing counts
    localparam logic [1:0] PRESC_LAST = 2'h3;
    localparam logic [3:0] SMP_LAST = 4'hf;
    localparam logic [3:0] SMP_MID = 4'h7;
    localparam logic [3:0] WORD_MIN = 4'h5;
    localparam int TO_WORDS = 4;
    localparam int TO_BITS = 12;
    localparam int SMP_PER_BIT = 16;

    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
        logic [7:0] data;
    } ubc_rx_ent_t;
endpackage

// ---- ubc_remote.sv ----
`timescale 1ns/100ps
module ubc_remote (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    int bit_clks = 16;
    initial rxd_o = 1'b1;
    ////////////////////////////////
    // frame to the core, start low for low_clks
    task automatic send(input logic [7:0] b, input int low_clks);
        rxd_o <= 1'b0;
        repeat (low_clks) @(posedge clk_i);
        for (int i = 0; i < 9 && low_clks >= bit_clks; i++)
        begin
            rxd_o <= (i < 8) ? b[i] : 1'b1;
            repeat (bit_clks) @(posedge clk_i);
        end
        if (low_clks < bit_clks)
            rxd_o <= 1'b1;
    endtask
    ////////////////////////////////
    // frame from the core, sampled mid-bit
    task automatic recv(input int nbits, output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        b = 8'h00;
        while (txd_i !== 1'b0 && n < 4000)
        begin
            @(posedge clk_i);
            n++;
        end
        repeat (bit_clks / 2) @(posedge clk_i);
        ok = (txd_i === 1'b0) && (n < 4000);
        for (int i = 0; i < nbits; i++)
        begin
            repeat (bit_clks) @(posedge clk_i);
            b[i] = txd_i;
        end
        repeat (bit_clks) @(posedge clk_i);
        ok = ok && (txd_i === 1'b1);
    endtask
endmodule // ubc_remote

// ---- ubc_core_tb.sv ----
`timescale 1ns/100ps
module ubc_core_tb
    import ubc_pkg::*;
;
    typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} ubc_row_t;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic [31:0] rd;
    logic pready_o, pslverr_o, txd_o, irq_o, rxd_i, err;
    int failures = 0;
    int num_checks = 0;
    ubc_row_t rows [9] = '{'{1'b0, A_DLL, 8'h00, DLL_RST}, '{1'b0, A_DLM, 8'h00, DLM_RST},
        '{1'b0, A_LSR, 8'h00, 8'h60}, '{1'b0, A_ISR, 8'h00, 8'h01}, '{1'b1, A_LCR, 8'h03, 8'h00},
        '{1'b0, A_LCR, 8'h00, 8'h03}, '{1'b1, A_DLL, 8'h02, 8'h00},
        '{1'b0, A_DLL, 8'h00, 8'h02}, '{1'b0, 8'h24, 8'h00, 8'h00}};
    ubc_core #(.DEPTH(16)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rxd_i(rxd_i),
        .txd_o(txd_o), .irq_o(irq_o));
    ubc_remote u_remote (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
    always #50 clk_i = ~clk_i;
    ////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cut_short();
        failures++;
        tally_and_finish();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h000000, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1)
        begin
            if (++n > 20)
                cut_short();
            @(posedge clk_i);
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic tx_expect(input int nbits, input logic [7:0] e);
        logic [7:0] b;
        logic ok;
        u_remote.recv(nbits, b, ok);
        if (ok !== 1'b1)
            cut_short();
        chk({24'h0, b}, {24'h0, e}, "serial byte");
    endtask
    ////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                chk(rd, {24'h0, rows[i].e}, "reg read");
        end
        chk({31'h0, err}, 32'h1, "unmapped");
        $display("test table done");
        u_remote.bit_clks = 32;
        fork
            tx_expect(8, 8'ha5);
            apb(1'b1, A_DATA, 8'ha5);
        join
        repeat (32) @(posedge clk_i);
        apb(1'b0, A_LSR, 8'h00);
        chk(rd, 32'h60, "lsr after tx");
        apb(1'b1, A_IER, 8'h02);
        apb(1'b0, A_ISR, 8'h00);
        chk(rd, 32'h02, "isr thr empty");
        chk({31'h0, irq_o}, 32'h1, "irq thr");
        apb(1'b1, A_IER, 8'h00);
        $display("test plain tx done");
        apb(1'b1, A_DLL, 8'h01);
        apb(1'b1, A_MCR, 8'h80);
        apb(1'b1, A_FCR, 8'h01);
        apb(1'b1, A_LCR, 8'h02);
        u_remote.bit_clks = 64;
        fork
            begin
                tx_expect(7, 8'h43);
                tx_expect(7, 8'h1e);
            end
            begin
                apb(1'b1, A_DATA, 8'hc3);
                apb(1'b1, A_DATA, 8'h9e);
                apb(1'b0, A_LSR, 8'h00);
                chk(rd, 32'h00, "lsr busy");
            end
        join
        apb(1'b1, A_IER, 8'h02);
        apb(1'b0, A_ISR, 8'h00);
        chk(rd, 32'hc2, "isr tx empty");
        chk({31'h0, irq_o}, 32'h1, "irq tx");
        apb(1'b1, A_LCR, 8'h1a);
        fork
            tx_expect(8, 8'hc3);
            apb(1'b1, A_DATA, 8'h43);
        join
        $display("test fifo tx done");
        apb(1'b1, A_LCR, 8'h03);
        apb(1'b1, A_IER, 8'h01);
        u_remote.send(8'h96, 64);
        u_remote.send(8'h2b, 64);
        apb(1'b0, A_LSR, 8'h00);
        chk(rd, 32'h61, "lsr rx");
        chk({31'h0, irq_o}, 32'h1, "irq rx");
        apb(1'b0, A_DATA, 8'h00);
        chk(rd, 32'h96, "rx first");
        apb(1'b0, A_DATA, 8'h00);
        chk(rd, 32'h2b, "rx second");
        apb(1'b1, A_FCR, 8'h41);
        u_remote.send(8'h5a, 64);
        apb(1'b0, A_ISR, 8'h00);
        chk(rd, 32'hc1, "below rx trigger");
        repeat (2900) @(posedge clk_i);
        apb(1'b0, A_ISR, 8'h00);
        chk(rd, 32'hcc, "isr time-out");
        chk({31'h0, irq_o}, 32'h1, "irq time-out");
        apb(1'b0, A_DATA, 8'h00);
        chk(rd, 32'h5a, "rx after time-out");
        u_remote.send(8'h00, 20);
        repeat (640) @(posedge clk_i);
        apb(1'b0, A_LSR, 8'h00);
        chk(rd, 32'h60, "false start");
        chk({31'h0, irq_o}, 32'h0, "irq idle");
        $display("test rx done");
        tally_and_finish();
    end
endmodule // ubc_core_tb
